// ---- verif/ust_slave_model.sv ----
// Purpose: Synchronous slave taking the port's shift clock and data
// Assumes: Bench resolves the wires; held in reset until clock is owned
// Notes:   Reports each word with its lead-in gap and bit period
`timescale 1ns/1ps

module ust_slave_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ckLine,
    input  wire logic        dtLine,
    input  wire logic        nine,
    output logic [8:0]       frame,
    output logic             frameDone,
    output logic [15:0]      gap,
    output logic [15:0]      period
);
    logic        ckD;       // Clock level one sample ago
    logic [3:0]  bitCnt;    // Bits taken in this word
    logic [8:0]  shReg;     // Word being assembled, enters at the top
    logic [15:0] sinceRise; // Clocks since the last rising edge

    // Data taken on each rise; dt moves on the fall, so it is settled
    always @(posedge clk) begin
        frameDone <= 1'b0;
        ckD       <= ckLine;
        if (rst) begin
            bitCnt    <= 4'h0;
            sinceRise <= 16'hFFF0;
        end else if (ckLine && !ckD) begin
            sinceRise <= 16'h0000;
            shReg     <= {dtLine, shReg[8:1]}; // LSB arrives first
            if (bitCnt == 4'h0) begin
                gap <= sinceRise + 16'h0001;
            end else begin
                period <= sinceRise + 16'h0001;
            end
            if (bitCnt == (nine ? 4'h8 : 4'h7)) begin
                bitCnt    <= 4'h0;
                frameDone <= 1'b1;
                frame     <= nine ? {dtLine, shReg[8:1]}
                                  : {1'b0, dtLine, shReg[8:2]};
            end else begin
                bitCnt <= bitCnt + 4'h1;
            end
        end else if (sinceRise != 16'hFFF0) begin
            // Saturates so an idle line never wraps
            sinceRise <= sinceRise + 16'h0001;
        end
    end
endmodule

// ---- verif/ust_sync_tx_tb_top.sv ----
// Purpose: Self-checking bench for the synchronous master transmitter
// Assumes: 40 MHz clk; baud divisor 1 gives the 200 ns shift clock
// Notes:   Reads and words are checked from queues by monitors
`timescale 1ns/1ps
`include "ust_cfg.svh"

module ust_sync_tx_tb_top;
    logic              clk;
    logic              rst;
    ust_pkg::ust_bus_s busReq;
    logic [7:0]        rdData;
    ust_pkg::ust_pin_s pins;
    logic              rxInhibit;
    logic              irq;
    logic              tgl = 1'b0;   // Level for wires nobody drives
    logic              nine;         // Slave word length
    logic [8:0]        frame;
    logic              frameDone;
    logic [15:0]       gap;
    logic [15:0]       period;
    logic              rdPend;       // Read data due this cycle
    logic [15:0]       bitClk;       // Expected clocks per bit
    logic [7:0]        rdQ[$];       // Expected read data
    logic [24:0]       frQ[$];       // {word, lead-in gap or 0}
    logic [24:0]       fe;
    logic [7:0]        d;
    int                bad_count;
    int                total_checks;

    // Undriven wires change every cycle so no stale value passes
    wire ckWire = pins.ckOe ? pins.ckOut : tgl;
    wire dtWire = pins.dtOe ? pins.dtOut : ~tgl;

    ust_sync_tx #(.DATA_W(8)) uut (
        .clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
        .ckIn(ckWire), .dtIn(dtWire), .pins(pins),
        .rxInhibit(rxInhibit), .irq(irq));

    // Slave listens only once the port owns the clock line
    ust_slave_model slave (
        .clk(clk), .rst(rst || !pins.ckOe), .ckLine(ckWire),
        .dtLine(dtWire), .nine(nine), .frame(frame),
        .frameDone(frameDone), .gap(gap), .period(period));

    // Clock and idle-wire pattern
    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    always @(posedge clk) tgl <= ~tgl;

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle strobes; a cycle passes before the next request
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        busReq <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] v);
        rdQ.push_back(v);
        @(posedge clk);
        busReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        busReq <= '0;
    endtask

    // Software loads the buffer last to start a word
    task automatic send(input logic [8:0] w, input logic [15:0] g);
        frQ.push_back({w, g});
        wr(`UST_OFF_HOLD, w[7:0]);
    endtask

    // Bounded wait for all queued words to arrive
    task automatic waitIdle;
        for (int i = 0; i < 4000 && frQ.size() != 0; i++) @(posedge clk);
        // Final half clock still runs after the slave's last sample
        for (int i = 0; i < 64 && rxInhibit; i++) @(posedge clk);
        if (frQ.size() != 0 || rxInhibit) begin
            bad_count++;
            $display("mismatch at %0t: words never arrived", $time);
            results();
        end
    endtask

    // Read monitor: data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rdPend <= busReq.rd;
        if (rdPend) begin
            chk({8'h00, rdData}, {8'h00, rdQ.pop_front()});
        end
    end

    // Word monitor: content, bit time and reload gap
    always @(posedge clk) begin
        if (frameDone) begin
            fe = frQ.pop_front();
            chk({7'h00, frame}, {7'h00, fe[24:16]});
            chk(period, bitClk);
            if (fe[15:0] != 16'h0000) chk(gap, fe[15:0]);
        end
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        busReq = '0;
        nine = 1'b0;
        bitClk = 16'd8;
        bad_count = 0;
        total_checks = 0;
        void'($urandom(20));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped offset B included; pins skipped
        for (int a = 0; a < 12; a++) begin
            if (a != 10) rd(a[3:0], a == 6 ? 8'h02 : 8'h00);
        end
        wr(`UST_OFF_TXS, 8'hFF);
        rd(`UST_OFF_TXS, 8'hF7);
        wr(`UST_OFF_PFL, 8'hFF);
        rd(`UST_OFF_PFL, 8'h00);
        // Divisor, then mode and pins, then transmit enable
        wr(`UST_OFF_BRG, 8'h01);
        wr(`UST_OFF_RCS, 8'h80);
        wr(`UST_OFF_TXS, 8'h90);
        wr(`UST_OFF_TXS, 8'hB0);
        @(negedge clk);
        chk({15'h0, pins.ckOe}, 16'h1);
        chk({15'h0, pins.ckOut}, 16'h0);
        // Word in flight while a second one waits
        d = 8'($urandom);
        send({1'b0, d}, 16'h0000);
        repeat (8) @(posedge clk);
        rd(`UST_OFF_TXS, 8'hB0);
        @(negedge clk);
        chk({15'h0, rxInhibit}, 16'h1);
        rd(`UST_OFF_PFL, 8'h10);
        d = 8'($urandom);
        send({1'b0, d}, bitClk + 16'd4);
        rd(`UST_OFF_PFL, 8'h00);
        rd(`UST_OFF_HOLD, d);
        waitIdle();
        rd(`UST_OFF_TXS, 8'hB2);
        // Buffer-empty request gated by its enable
        @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        wr(`UST_OFF_PEN, 8'h10);
        @(negedge clk);
        chk({15'h0, irq}, 16'h1);
        wr(`UST_OFF_PEN, 8'h00);
        rd(`UST_OFF_EVT, 8'h03);
        wr(`UST_OFF_EMSK, 8'h01);
        @(negedge clk);
        chk({15'h0, irq}, 16'h1);
        wr(`UST_OFF_EVT, 8'h03);
        rd(`UST_OFF_EVT, 8'h00);
        @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        // Nine-bit words with both ninth values
        nine <= 1'b1;
        for (int n = 0; n < 2; n++) begin
            d = 8'($urandom);
            wr(`UST_OFF_TXS, 8'hF0 | n[7:0]);
            send({n[0], d}, 16'h0000);
            waitIdle();
        end
        // Slower divisor
        nine <= 1'b0;
        wr(`UST_OFF_TXS, 8'hB0);
        wr(`UST_OFF_BRG, 8'h03);
        bitClk = 16'd16;
        d = 8'($urandom);
        send({1'b0, d}, 16'h0000);
        waitIdle();
        // Transmit enable dropped mid-word: word is abandoned
        wr(`UST_OFF_HOLD, 8'hA5);
        repeat (20) @(posedge clk);
        wr(`UST_OFF_TXS, 8'h90);
        // Sequencer leaves the frame at the edge after the write
        repeat (2) @(negedge clk);
        chk({15'h0, pins.dtOe}, 16'h0);
        chk({15'h0, rxInhibit}, 16'h0);
        rd(`UST_OFF_TXS, 8'h92);
        // Reset in mid-run brings the defaults back
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(`UST_OFF_TXS, 8'h02);
        rd(`UST_OFF_PFL, 8'h00);
        @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        repeat (4) @(posedge clk);
        results();
    end
endmodule

// ---- verilog/ust_cfg.svh ----
// Purpose: Offsets, bit positions, reset values and timing of the port
// Assumes: Included by the bench and the transmitter
// Notes:   Definitions only
`ifndef UST_CFG_SVH
`define UST_CFG_SVH

// Register offsets on the plain register port
`define UST_OFF_GIC   4'h0
`define UST_OFF_PFL   4'h1
`define UST_OFF_PEN   4'h2
`define UST_OFF_PPR   4'h3
`define UST_OFF_RCS   4'h4
`define UST_OFF_HOLD  4'h5
`define UST_OFF_TXS   4'h6
`define UST_OFF_BRG   4'h7
`define UST_OFF_EVT   4'h8
`define UST_OFF_EMSK  4'h9
`define UST_OFF_PINS  4'hA

// Transmit status/control bit positions
`define UST_TXS_CLOCK_SOURCE_SELECT  7
`define UST_TXS_TX9   6
`define UST_TXS_TX_ENABLE  5
`define UST_TXS_SYNC  4
`define UST_TXS_SHIFT_REGISTER_EMPTY  1
`define UST_TXS_TX_NINTH_BIT  0
// Writable bits of transmit status/control
`define UST_TXS_WMSK  8'hF5
// Receive status/control: port enable and writable bits
`define UST_RCS_SERIAL_PORT_ON  7
`define UST_RCS_WMSK  8'hF8
// Buffer-empty flag and its enable
`define UST_PFL_TX_BUFFER_EMPTY_FLAG  4
`define UST_PEN_TX_BUFFER_IRQ_ENABLE  4
// Event bits: frame shifted out, byte moved to shift register
`define UST_EVT_DONE  0
`define UST_EVT_LOAD  1

// Reset values
`define UST_TXS_RST   8'h02
`define UST_REG_RST   8'h00

// Timing in nanoseconds
`define UST_TCY_NS    100
`define UST_CLK_NS    25

`endif

// ---- verilog/ust_pkg.sv ----
// Purpose: Types shared by the transmitter and its bench
// Assumes: Constants live in ust_cfg.svh
// Notes:   Nothing here is imported; use ust_pkg::name
package ust_pkg;
    // Transmit sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT
    } ust_tx_e;

    // One register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ust_bus_s;

    // Drive side of the two port pins
    typedef struct packed {
        logic ckOut;
        logic ckOe;
        logic dtOut;
        logic dtOe;
    } ust_pin_s;
endpackage

// ---- verilog/ust_sync_tx.sv ----
// Purpose: Synchronous master transmit path of a serial port
// Assumes: 40 MHz clk, synchronous active-high rst
// Notes:   Shift clock is made here from the baud divisor
//
// Contract
// - Half duplex: transmit inhibits reception
// - Sync select bit enters synchronous mode
// - Port enable hands pins to clock/data
// - Clock source set: device drives clock
// - No reload before last bit leaves
// - Reload right after last bit if pending
// - Move takes one instruction cycle, sets flag
// - Buffer-empty request gated by enable bit
// - Flag ignores enable; only buffer write clears
// - Shift-empty bit read-only, polled, no interrupt
// - Shift register has no address
// - Ninth bit sent when nine-bit selected
// - Transmit status/control resets to 0x02
`timescale 1ns/1ps
`include "ust_cfg.svh"

module ust_sync_tx #(
    parameter int DATA_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire ust_pkg::ust_bus_s busReq,
    output logic [7:0]            rdData,
    input  wire logic             ckIn,
    input  wire logic             dtIn,
    output ust_pkg::ust_pin_s     pins,
    output logic                  rxInhibit,
    output logic                  irq
);
    // Registers are byte wide; the logic serves nothing else
    if (DATA_W != 8) begin : g_chk
        $error("ust_sync_tx: DATA_W must be 8");
    end

    // Clocks per instruction cycle, rounded up
    localparam int TCY_CYC =
        (`UST_TCY_NS + `UST_CLK_NS - 1) / `UST_CLK_NS;
    localparam logic [2:0] LOAD_LAST = 3'(TCY_CYC - 1);

    // Software-visible state
    logic [7:0] gic_r;     // Global interrupt control, storage
    logic [7:0] pen_r;     // Peripheral enables
    logic [7:0] ppr_r;     // Peripheral priorities, storage
    logic [7:0] rcs_r;     // Receive status/control
    logic [7:0] txs_r;     // Transmit status/control, writable bits
    logic [7:0] hold_r;    // Holding buffer
    logic [7:0] brg_r;     // Baud divisor
    logic       tx_buffer_empty_flag_r;    // Buffer-empty flag
    logic       pend_r;    // Holding buffer has a byte
    logic [1:0] evt_r;     // Sticky events
    logic [1:0] emsk_r;    // Event mask
    logic [7:0] rdData_r;  // Read data, one cycle after strobe

    // Transmit sequencer state
    ust_pkg::ust_tx_e state_r;
    logic [2:0] loadCnt_r; // Clocks spent moving a byte
    logic [8:0] divCnt_r;  // Half shift-clock divider
    logic [3:0] bitCnt_r;  // Bits sent in this frame
    logic [8:0] tsr_r;     // Shift register, not addressable
    logic       ckLvl_r;   // Shift clock level
    logic       dt_r;      // Data level

    // Pin synchronisers; first stage read only by second
    logic [1:0] ckSync_r;
    logic [1:0] dtSync_r;

    // Decoded bus strobes
    logic txWr;
    logic wrPen, wrGic, wrPpr, wrRcs, wrTxs, wrBrg, wrEvt, wrEmsk;
    assign txWr   = busReq.wr && busReq.addr == `UST_OFF_HOLD;
    assign wrGic  = busReq.wr && busReq.addr == `UST_OFF_GIC;
    assign wrPen  = busReq.wr && busReq.addr == `UST_OFF_PEN;
    assign wrPpr  = busReq.wr && busReq.addr == `UST_OFF_PPR;
    assign wrRcs  = busReq.wr && busReq.addr == `UST_OFF_RCS;
    assign wrTxs  = busReq.wr && busReq.addr == `UST_OFF_TXS;
    assign wrBrg  = busReq.wr && busReq.addr == `UST_OFF_BRG;
    assign wrEvt  = busReq.wr && busReq.addr == `UST_OFF_EVT;
    assign wrEmsk = busReq.wr && busReq.addr == `UST_OFF_EMSK;

    // Mode decode
    logic serial_port_on, sync, clock_source_select, run, nine;
    assign serial_port_on = rcs_r[`UST_RCS_SERIAL_PORT_ON];
    assign sync = txs_r[`UST_TXS_SYNC];
    assign clock_source_select = txs_r[`UST_TXS_CLOCK_SOURCE_SELECT];
    // Shifting needs all of mode, pins, master clock and enable
    assign run  = serial_port_on && sync && clock_source_select && txs_r[`UST_TXS_TX_ENABLE];
    assign nine = txs_r[`UST_TXS_TX9];

    // Sequencer decode
    logic stLoad, stShift, halfTick, lastBit, frameEnd;
    logic loadEnd, loadStart;
    assign stLoad   = state_r == ust_pkg::ST_LOAD;
    assign stShift  = state_r == ust_pkg::ST_SHIFT;
    // Half period is 2*(divisor+1) clocks, bit is 4*(divisor+1)
    assign halfTick = divCnt_r == {brg_r, 1'b1};
    assign lastBit  = bitCnt_r == (nine ? 4'h8 : 4'h7);
    // Falling clock edge of the final bit ends the frame
    assign frameEnd = stShift && halfTick && ckLvl_r && lastBit;
    assign loadEnd  = stLoad && loadCnt_r == LOAD_LAST;
    // Byte leaves the buffer when idle or right at frame end
    assign loadStart = run && pend_r &&
        (state_r == ust_pkg::ST_IDLE || frameEnd);

    // Plain storage registers
    always_ff @(posedge clk) begin
        if (rst) begin
            gic_r  <= `UST_REG_RST;
            pen_r  <= `UST_REG_RST;
            ppr_r  <= `UST_REG_RST;
            brg_r  <= `UST_REG_RST;
            hold_r <= `UST_REG_RST;
            emsk_r <= 2'h0;
        end else begin
            if (wrGic)  gic_r  <= busReq.wdata;
            if (wrPen)  pen_r  <= busReq.wdata;
            if (wrPpr)  ppr_r  <= busReq.wdata;
            if (wrBrg)  brg_r  <= busReq.wdata;
            if (txWr)   hold_r <= busReq.wdata;
            if (wrEmsk) emsk_r <= busReq.wdata[1:0];
        end
    end

    // Mode registers; shift-empty bit is never stored
    always_ff @(posedge clk) begin
        if (rst) begin
            txs_r <= `UST_TXS_RST & `UST_TXS_WMSK;
            rcs_r <= `UST_REG_RST;
        end else begin
            if (wrTxs) txs_r <= busReq.wdata & `UST_TXS_WMSK;
            if (wrRcs) rcs_r <= busReq.wdata & `UST_RCS_WMSK;
        end
    end

    // Pending byte: a new write wins over the move out
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (txWr) begin
            pend_r <= 1'b1;
        end else if (loadStart) begin
            pend_r <= 1'b0;
        end
    end

    // Buffer-empty flag: set after the move, cleared by a buffer write
    // Writes to the flag register itself have no effect
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_buffer_empty_flag_r <= 1'b0;
        end else if (loadEnd && !pend_r && !txWr) begin
            tx_buffer_empty_flag_r <= 1'b1;
        end else if (txWr) begin
            tx_buffer_empty_flag_r <= 1'b0;
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            evt_r <= 2'h0;
        end else begin
            evt_r[`UST_EVT_DONE] <= frameEnd ||
                (evt_r[`UST_EVT_DONE] &&
                 !(wrEvt && busReq.wdata[`UST_EVT_DONE]));
            evt_r[`UST_EVT_LOAD] <= loadEnd ||
                (evt_r[`UST_EVT_LOAD] &&
                 !(wrEvt && busReq.wdata[`UST_EVT_LOAD]));
        end
    end

    // Transmit sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= ust_pkg::ST_IDLE;
            loadCnt_r <= 3'h0;
            divCnt_r  <= 9'h000;
            bitCnt_r  <= 4'h0;
            tsr_r     <= 9'h000;
            ckLvl_r   <= 1'b0;
            dt_r      <= 1'b0;
        end else if (!run) begin
            // Leaving the mode abandons a frame; clock idles low
            state_r <= ust_pkg::ST_IDLE;
            ckLvl_r <= 1'b0;
        end else if (loadStart) begin
            // Byte is copied here; a buffer write in this same cycle
            // stays pending for the next frame instead of being lost
            // Ninth bit rides above the byte
            state_r   <= ust_pkg::ST_LOAD;
            loadCnt_r <= 3'h0;
            tsr_r     <= {nine & txs_r[`UST_TXS_TX_NINTH_BIT], hold_r};
            ckLvl_r   <= 1'b0;
        end else begin
            case (state_r)
                ust_pkg::ST_IDLE: begin
                    // Clock rests low with nothing pending
                    ckLvl_r <= 1'b0;
                end
                ust_pkg::ST_LOAD: begin
                    // Move lasts one instruction cycle
                    loadCnt_r <= loadCnt_r + 3'h1;
                    if (loadEnd) begin
                        state_r  <= ust_pkg::ST_SHIFT;
                        divCnt_r <= 9'h000;
                        bitCnt_r <= 4'h0;
                        dt_r     <= tsr_r[0];
                    end
                end
                ust_pkg::ST_SHIFT: begin
                    // Divider restarts each half so both halves match
                    divCnt_r <= halfTick ? 9'h000 : divCnt_r + 9'h001;
                    if (halfTick) begin
                        ckLvl_r <= !ckLvl_r;
                        // Data moves on the falling edge, LSB first
                        if (ckLvl_r && !lastBit) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                            tsr_r    <= {1'b0, tsr_r[8:1]};
                            dt_r     <= tsr_r[1];
                        end else if (ckLvl_r) begin
                            state_r <= ust_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ust_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pin level synchronisers
    always_ff @(posedge clk) begin
        if (rst) begin
            ckSync_r <= 2'h0;
            dtSync_r <= 2'h0;
        end else begin
            ckSync_r <= {ckSync_r[0], ckIn};
            dtSync_r <= {dtSync_r[0], dtIn};
        end
    end

    // Read mux; the shift register has no slot here
    logic [7:0] rdMux;
    always_comb begin
        case (busReq.addr)
            `UST_OFF_GIC:  rdMux = gic_r;
            `UST_OFF_PFL:  rdMux = 8'(tx_buffer_empty_flag_r) << `UST_PFL_TX_BUFFER_EMPTY_FLAG;
            `UST_OFF_PEN:  rdMux = pen_r;
            `UST_OFF_PPR:  rdMux = ppr_r;
            `UST_OFF_RCS:  rdMux = rcs_r;
            `UST_OFF_HOLD: rdMux = hold_r;
            `UST_OFF_TXS:  rdMux = txs_r |
                (8'(!stShift) << `UST_TXS_SHIFT_REGISTER_EMPTY);
            `UST_OFF_BRG:  rdMux = brg_r;
            `UST_OFF_EVT:  rdMux = {6'h00, evt_r};
            `UST_OFF_EMSK: rdMux = {6'h00, emsk_r};
            `UST_OFF_PINS: rdMux = {6'h00, ckSync_r[1], dtSync_r[1]};
            default:       rdMux = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    // Zero elsewhere, so a late sample never sees stale data
    always_ff @(posedge clk) begin
        if (rst) begin
            rdData_r <= 8'h00;
        end else begin
            rdData_r <= busReq.rd ? rdMux : 8'h00;
        end
    end
    assign rdData = rdData_r;

    // Pins; data released whenever no frame is in progress
    assign pins.ckOut = ckLvl_r;
    assign pins.ckOe  = serial_port_on && sync && clock_source_select;
    assign pins.dtOut = dt_r;
    assign pins.dtOe  = serial_port_on && sync && stShift;
    // Receiver must stay off while a byte is in flight
    assign rxInhibit  = state_r != ust_pkg::ST_IDLE;

    // Shift-empty raises nothing; only the flag and events do
    // Global control and priorities are storage only here
    assign irq = (tx_buffer_empty_flag_r && pen_r[`UST_PEN_TX_BUFFER_IRQ_ENABLE]) ||
                 |(evt_r & emsk_r);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Move and shift, as steps
    sequence moveSeq;
        stLoad [*4];
    endsequence
    sequence firstBit;
        stShift && !ckLvl_r && dt_r == $past(tsr_r[0]);
    endsequence
    // Final falling clock edge of a frame in running mode
    sequence lastFall;
        frameEnd && run;
    endsequence
    // After it the sequencer reloads or rests, never shifts on
    sequence afterFrame;
        stLoad || state_r == ust_pkg::ST_IDLE;
    endsequence

    half_duplex_a: assert property (
        stShift |-> rxInhibit && pins.dtOe)
        else $error("Reception not inhibited while sending");
    mode_exit_a: assert property (
        !sync |-> !pins.ckOe ##1 state_r == ust_pkg::ST_IDLE)
        else $error("Shifting outside synchronous mode");
    pin_release_a: assert property (
        !serial_port_on |-> !pins.ckOe && !pins.dtOe)
        else $error("Pins driven with port disabled");
    master_clock_a: assert property (
        serial_port_on && sync && clock_source_select |-> pins.ckOe)
        else $error("Master not driving clock line");
    no_early_a: assert property (
        stShift && !frameEnd && run |=> !stLoad)
        else $error("Reload before last bit left");
    reload_now_a: assert property (
        frameEnd && run && pend_r |=> stLoad)
        else $error("No reload after last bit");
    move_time_a: assert property (
        @(posedge clk) disable iff (rst || !run)
        $rose(stLoad) |-> moveSeq ##1 firstBit)
        else $error("Move not one instruction cycle");
    flag_set_a: assert property (
        loadEnd && !pend_r && !txWr |=> tx_buffer_empty_flag_r && !pend_r)
        else $error("Buffer-empty flag not set");
    flag_hold_a: assert property (
        tx_buffer_empty_flag_r && !txWr |=> tx_buffer_empty_flag_r)
        else $error("Buffer-empty flag lost without write");
    irq_gate_a: assert property (
        !pen_r[`UST_PEN_TX_BUFFER_IRQ_ENABLE] && (evt_r & emsk_r) == 2'h0 |-> !irq)
        else $error("Masked request reached interrupt");
    shift_empty_a: assert property (
        busReq.rd && busReq.addr == `UST_OFF_TXS
        |=> rdData[`UST_TXS_SHIFT_REGISTER_EMPTY] == !$past(stShift))
        else $error("Shift-empty bit wrong");
    reset_val_a: assert property (
        $past(rst) |-> (txs_r | 8'(!stShift) << 1) == `UST_TXS_RST)
        else $error("Status/control reset value wrong");

    // Sequencer shape: frame boundary, data steps and clock levels
    frame_close_a: assert property (
        lastFall |=> afterFrame)
        else $error("Frame did not close at last bit");
    bit_step_a: assert property (
        run && stShift && halfTick && ckLvl_r && !lastBit
        |=> dt_r == $past(tsr_r[1]))
        else $error("Data bit not advanced on falling clock");
    clock_hold_a: assert property (
        run && stShift && !halfTick |=> $stable(ckLvl_r))
        else $error("Shift clock moved between half periods");
    clock_idle_a: assert property (
        state_r == ust_pkg::ST_IDLE |-> !pins.ckOut)
        else $error("Shift clock not resting low when idle");

    // Register side: flag clear, interrupt raise, unmapped reads
    flag_clear_a: assert property (
        txWr |=> !tx_buffer_empty_flag_r)
        else $error("Buffer write did not clear flag");
    irq_raise_a: assert property (
        tx_buffer_empty_flag_r && pen_r[`UST_PEN_TX_BUFFER_IRQ_ENABLE] |-> irq)
        else $error("Enabled buffer-empty flag gave no interrupt");
    no_slot_a: assert property (
        busReq.rd && busReq.addr > `UST_OFF_PINS |=> rdData == 8'h00)
        else $error("Unmapped offset returned data");
endmodule
